// ### hdl/adcsc_pkg.sv
/*
  Package for the converter start and flag control block.
  Assumes a byte-wide register port and a 10 MHz system clock.
*/
package adcsc_pkg;
  // Register indices (byte addresses on the plain port)
  localparam logic [3:0] ADDR_CTRL = 4'h0;
  localparam logic [3:0] ADDR_RES_HIGH = 4'h1;
  localparam logic [3:0] ADDR_RES_LOW = 4'h2;
  localparam logic [3:0] ADDR_IRQ_STATUS = 4'h3;
  localparam logic [3:0] ADDR_IRQ_CLEAR = 4'h4;
  localparam logic [3:0] ADDR_IRQ_ENABLE = 4'h5;
  // Control register field positions
  localparam int BIT_BUSY = 4;
  localparam int BIT_SRC_HI = 3;
  localparam int BIT_SRC_LO = 2;
  localparam int BIT_WINDOW = 1;
  localparam int BIT_ALIGN = 0;
  // Interrupt status bit positions
  localparam int IRQ_DONE = 0;
  localparam int IRQ_WINDOW = 1;
  localparam int IRQ_BITS = 2;
  // Reset values
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [1:0] IRQ_EN_RESET = 2'h0;
  // Conversion length in clock cycles
  localparam int CONV_TIME_NS = 1600;
  localparam int CLK_PERIOD_NS = 100;
  localparam logic [4:0] CONV_CYCLES = 5'((CONV_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam int RESULT_WIDTH = 10;

  typedef enum logic [1:0] {
    SRC_SOFTWARE,
    SRC_TIMER3,
    SRC_EXT_PIN,
    SRC_TIMER2
  } adcsc_src_t;

  typedef enum logic [0:0] {
    ST_IDLE,
    ST_CONVERT
  } adcsc_state_t;
endpackage

// ### hdl/adcsc_start_if.sv
/*
  Interface between the control block and its trigger selector.
  Assumes both ends share clk_sys.
*/
`timescale 1ns/10ps
interface adcsc_start_if;
  logic [1:0] source;
  logic sw_start;
  logic timer3_ovf;
  logic timer2_ovf;
  logic pin_rise;
  logic start;

  modport ctrl (output source, output sw_start, output timer3_ovf, output timer2_ovf,
    output pin_rise, input start);
  modport sel (input source, input sw_start, input timer3_ovf, input timer2_ovf,
    input pin_rise, output start);
endinterface

// ### hdl/adcsc_trigger_sel.sv
/*
  Start-of-conversion trigger selector.
  Assumes every trigger input is a one-cycle pulse on clk_sys.
*/
`timescale 1ns/10ps
module adcsc_trigger_sel (
  adcsc_start_if.sel trig
);
  always_comb begin
    case (adcsc_pkg::adcsc_src_t'(trig.source))
      adcsc_pkg::SRC_SOFTWARE: trig.start = trig.sw_start;
      adcsc_pkg::SRC_TIMER3: trig.start = trig.timer3_ovf;
      adcsc_pkg::SRC_EXT_PIN: trig.start = trig.pin_rise;
      adcsc_pkg::SRC_TIMER2: trig.start = trig.timer2_ovf;
      default: trig.start = 1'b0;
    endcase
  end
endmodule

// ### hdl/adcsc_control.sv
/*
  Converter start and flag control: control register, trigger choice,
  busy timing, window flag, result alignment and interrupt.
  Assumes timer overflows and window match are clk_sys pulses; the
  convert pin is asynchronous; the analog core delivers data when done.
*/
`timescale 1ns/10ps
module adcsc_control (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Register port
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // Trigger sources
  input wire logic timer3_ovf,
  input wire logic timer2_ovf,
  input wire logic external_convert_pin,
  // Converter core
  input wire logic window_match,
  input wire logic [9:0] conv_data,
  output logic conv_start,
  // Interrupt
  output logic irq
);
  typedef struct packed {
    adcsc_pkg::adcsc_state_t state;
    logic [4:0] count;
    logic [1:0] source;
    logic window_match_flag;
    logic result_alignment_bit;
    logic [2:0] pin_sync;
    logic pin_level;
    logic [7:0] result_high_byte;
    logic [7:0] result_low_byte;
    logic [1:0] irq_status;
    logic [1:0] irq_enable;
    logic [7:0] rdata;
    logic start_pulse;
  } adcsc_regs_t;

  adcsc_regs_t st_reg;
  adcsc_regs_t st_next;
  adcsc_start_if trig_if ();

  function automatic logic hit(input logic [3:0] addr, input logic [3:0] target);
    hit = (addr == target);
  endfunction

  logic wr_ctrl;
  logic busy;
  logic [15:0] aligned;

  assign wr_ctrl = reg_wr && hit(reg_addr, adcsc_pkg::ADDR_CTRL);
  assign busy = (st_reg.state == adcsc_pkg::ST_CONVERT);
  assign aligned = st_reg.result_alignment_bit ? {conv_data, 6'h00} : {6'h00, conv_data};

  assign trig_if.source = st_reg.source;
  assign trig_if.sw_start = wr_ctrl && reg_wdata[adcsc_pkg::BIT_BUSY];
  assign trig_if.timer3_ovf = timer3_ovf;
  assign trig_if.timer2_ovf = timer2_ovf;
  assign trig_if.pin_rise = (st_reg.pin_sync[2:1] == 2'b11) && !st_reg.pin_level;

  adcsc_trigger_sel u_sel (
    .trig(trig_if.sel)
  );

  always_comb begin
    st_next = st_reg;
    st_next.start_pulse = 1'b0;
    st_next.pin_sync = {st_reg.pin_sync[1:0], external_convert_pin};
    if (st_reg.pin_sync[2] == st_reg.pin_sync[1]) begin
      st_next.pin_level = st_reg.pin_sync[1];
    end
    if (wr_ctrl) begin
      st_next.source = reg_wdata[adcsc_pkg::BIT_SRC_HI:adcsc_pkg::BIT_SRC_LO];
      st_next.result_alignment_bit = reg_wdata[adcsc_pkg::BIT_ALIGN];
      if (!reg_wdata[adcsc_pkg::BIT_WINDOW]) begin
        st_next.window_match_flag = 1'b0;
      end
    end
    if (window_match) begin
      st_next.window_match_flag = 1'b1;
      st_next.irq_status[adcsc_pkg::IRQ_WINDOW] = 1'b1;
    end
    case (st_reg.state)
      adcsc_pkg::ST_IDLE: begin
        if (trig_if.start) begin
          st_next.state = adcsc_pkg::ST_CONVERT;
          st_next.count = adcsc_pkg::CONV_CYCLES;
          st_next.start_pulse = 1'b1;
        end
      end
      adcsc_pkg::ST_CONVERT: begin
        if (st_reg.count == 5'h01) begin
          st_next.state = adcsc_pkg::ST_IDLE;
          st_next.result_high_byte = aligned[15:8];
          st_next.result_low_byte = aligned[7:0];
        end
        st_next.count = st_reg.count - 5'h01;
      end
      default: st_next.state = adcsc_pkg::ST_IDLE;
    endcase
    if (reg_wr && hit(reg_addr, adcsc_pkg::ADDR_IRQ_CLEAR)) begin
      st_next.irq_status = st_reg.irq_status & ~reg_wdata[1:0];
    end
    if (reg_wr && hit(reg_addr, adcsc_pkg::ADDR_IRQ_ENABLE)) begin
      st_next.irq_enable = reg_wdata[1:0];
    end
    if (busy && st_reg.count == 5'h01) begin
      st_next.irq_status[adcsc_pkg::IRQ_DONE] = 1'b1;
    end
    if (window_match) begin
      st_next.irq_status[adcsc_pkg::IRQ_WINDOW] = 1'b1;
    end
    st_next.rdata = 8'h00;
    if (reg_rd) begin
      case (reg_addr)
        adcsc_pkg::ADDR_CTRL: st_next.rdata = {3'h0, busy, st_reg.source,
          st_reg.window_match_flag, st_reg.result_alignment_bit};
        adcsc_pkg::ADDR_RES_HIGH: st_next.rdata = st_reg.result_high_byte;
        adcsc_pkg::ADDR_RES_LOW: st_next.rdata = st_reg.result_low_byte;
        adcsc_pkg::ADDR_IRQ_STATUS: st_next.rdata = {6'h00, st_reg.irq_status};
        adcsc_pkg::ADDR_IRQ_ENABLE: st_next.rdata = {6'h00, st_reg.irq_enable};
        default: st_next.rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      st_reg <= '0;
      st_reg.state <= adcsc_pkg::ST_IDLE;
      st_reg.irq_enable <= adcsc_pkg::IRQ_EN_RESET;
    end else begin
      st_reg <= st_next;
    end
  end

  assign reg_rdata = st_reg.rdata;
  assign conv_start = st_reg.start_pulse;
  assign irq = |(st_reg.irq_status & st_reg.irq_enable);
endmodule

// ### tb/adcsc_checker.sv
/*
  Port checker for the converter start and flag control.
  Assumes it is bound to adcsc_control and sees only its ports.
*/
`timescale 1ns/10ps
module adcsc_checker (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Register port
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  // Triggers and outputs
  input wire logic timer3_ovf,
  input wire logic timer2_ovf,
  input wire logic external_convert_pin,
  input wire logic window_match,
  input wire logic conv_start,
  input wire logic irq
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  logic [4:0] cnt;
  logic [1:0] src;
  logic [1:0] en;
  logic ctl_wr;
  assign ctl_wr = reg_wr && reg_addr == 4'h0;
  // Shadow of source, enable and a busy window longer than a conversion
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      cnt <= 5'h00;
      src <= 2'h0;
      en <= 2'h0;
    end else begin
      cnt <= conv_start ? 5'h12 : cnt - 5'(cnt != 5'h00);
      src <= ctl_wr ? reg_wdata[3:2] : src;
      en <= (reg_wr && reg_addr == 4'h5) ? reg_wdata[1:0] : en;
    end
  end
  sequence quiet_run;
    !conv_start [*8];
  endsequence
  one_shot_a: assert property (conv_start |=> quiet_run)
    else $error("start while busy");
  sw_start_a: assert property (ctl_wr && reg_wdata[4] && reg_wdata[3:2] == 2'h0
    && src == 2'h0 && cnt == 5'h00 && !conv_start |=> conv_start) else $error("no sw start");
  zero_write_a: assert property (ctl_wr && !reg_wdata[4] && src == 2'h0 |=> !conv_start)
    else $error("start on zero write");
  t3_start_a: assert property (src == 2'h1 && timer3_ovf && cnt == 5'h00
    && !conv_start |=> conv_start) else $error("no timer3 start");
  t2_start_a: assert property (src == 2'h3 && timer2_ovf && cnt == 5'h00
    && !conv_start |=> conv_start) else $error("no timer2 start");
  pin_start_a: assert property (src == 2'h2 && cnt == 5'h00
    && $rose(external_convert_pin) |-> ##[2:6] conv_start) else $error("no pin start");
  done_irq_a: assert property (conv_start && en[0] |-> ##[15:20] irq)
    else $error("no done irq");
  win_irq_a: assert property (window_match && en[1] |-> ##[1:2] irq)
    else $error("no window irq");
  irq_mask_a: assert property (en == 2'h0 && $past(en) == 2'h0 |-> !irq)
    else $error("irq while masked");
  rd_idle_a: assert property (!reg_rd |=> reg_rdata == 8'h00)
    else $error("read data without read");
  reset_out_a: assert property (disable iff (1'b0) !rst_n |=> !conv_start && !irq)
    else $error("outputs after reset");
endmodule
bind adcsc_control adcsc_checker u_chk (
  .clk_sys(clk_sys),
  .rst_n(rst_n),
  .reg_addr(reg_addr),
  .reg_wdata(reg_wdata),
  .reg_wr(reg_wr),
  .reg_rd(reg_rd),
  .reg_rdata(reg_rdata),
  .timer3_ovf(timer3_ovf),
  .timer2_ovf(timer2_ovf),
  .external_convert_pin(external_convert_pin),
  .window_match(window_match),
  .conv_start(conv_start),
  .irq(irq)
);

// ### tb/tb_adcsc_control.sv
/*
  Self-checking bench for adcsc_control.
  Assumes the package, design and checker are compiled before it.
*/
`timescale 1ns/10ps
module tb_adcsc_control;
  logic clk_sys, rst_n, reg_wr, reg_rd, conv_start, irq;
  logic timer3_ovf, timer2_ovf, external_convert_pin, window_match;
  logic [3:0] reg_addr, tg;
  logic [7:0] reg_wdata, reg_rdata, d8;
  logic [9:0] conv_data;
  int fail_count, num_checks, seed, starts, s0;
  assign {window_match, timer2_ovf, external_convert_pin, timer3_ovf} = tg;
  adcsc_control u_dut (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_wr(reg_wr),
    .reg_rd(reg_rd),
    .reg_rdata(reg_rdata),
    .timer3_ovf(timer3_ovf),
    .timer2_ovf(timer2_ovf),
    .external_convert_pin(external_convert_pin),
    .window_match(window_match),
    .conv_data(conv_data),
    .conv_start(conv_start),
    .irq(irq)
  );
  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) if (conv_start === 1'b1) starts <= starts + 1;
  function automatic logic [7:0] res(input logic [9:0] d, input logic al, input logic h);
    logic [15:0] w;
    w = al ? {d, 6'h00} : {6'h00, d};
    return h ? w[15:8] : w[7:0];
  endfunction
  task automatic wrap_up();
    $display("checks %0d errors %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    @(posedge clk_sys);
  endtask
  task automatic rd(input logic [3:0] a);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 d8 = reg_rdata;
    @(posedge clk_sys);
  endtask
  task automatic fire(input logic [3:0] t, input int n);
    tg <= t;
    repeat (n) @(posedge clk_sys);
    tg <= 4'h0;
  endtask
  task automatic wait_start();
    for (int j = 0; j < 40 && starts == s0; j++) @(posedge clk_sys);
    if (starts == s0) begin
      $display("[ERR] %0t no conversion start", $time);
      fail_count++;
      wrap_up();
    end
  endtask
  initial begin
    {rst_n, reg_wr, reg_rd, reg_addr, reg_wdata, tg, conv_data} = '0;
    seed = 32'h55a8;
    repeat (3) @(posedge clk_sys);
    rst_n <= 1'b1;
    rd(4'h0);
    chk(d8, 8'h00);
    wr(4'h5, 8'h03);
    for (int k = 0; k < 4; k++) begin
      conv_data <= (k == 0) ? 10'h3ff : 10'($random(seed));
      s0 = starts;
      wr(4'h0, {7'h08, k[0]});
      wait_start();
      chk(8'(starts - s0), 8'h01);
      rd(4'h0);
      chk(d8 & 8'h10, 8'h10);
      repeat (20) @(posedge clk_sys);
      rd(4'h0);
      chk(d8 & 8'h10, 8'h00);
      rd(4'h1);
      chk(d8, res(conv_data, k[0], 1'b1));
      rd(4'h2);
      chk(d8, res(conv_data, k[0], 1'b0));
      chk({7'h00, irq}, 8'h01);
      wr(4'h4, 8'h01);
      chk({7'h00, irq}, 8'h00);
    end
    s0 = starts;
    wr(4'h0, 8'h00);
    repeat (20) @(posedge clk_sys);
    chk(8'(starts - s0), 8'h00);
    for (int m = 1; m < 4; m++) begin
      wr(4'h0, 8'(m << 2));
      s0 = starts;
      fire(4'(1 << (m - 1)), (m == 2) ? 6 : 1);
      wait_start();
      chk(8'(starts - s0), 8'h01);
      repeat (20) @(posedge clk_sys);
    end
    wr(4'h4, 8'h03);
    fire(4'h8, 1);
    rd(4'h0);
    chk(d8 & 8'h02, 8'h02);
    chk({7'h00, irq}, 8'h01);
    rd(4'h3);
    chk(d8, 8'h02);
    rd(4'h5);
    chk(d8, 8'h03);
    wr(4'h0, 8'h02);
    repeat (30) @(posedge clk_sys);
    rd(4'h0);
    chk(d8 & 8'h02, 8'h02);
    wr(4'h5, 8'h00);
    chk({7'h00, irq}, 8'h00);
    wr(4'h0, 8'h00);
    rd(4'h0);
    chk(d8 & 8'h02, 8'h00);
    wrap_up();
  end
endmodule
